// file: logic/byte_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PTR_W = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W:0] wr_ptr_reg;
   logic [PTR_W:0] rd_ptr_reg;
   logic push;
   logic pop;

   // ==========================================================
   // full when pointers differ only in the wrap bit
   assign in_ready = !((wr_ptr_reg[PTR_W] != rd_ptr_reg[PTR_W]) &&
                       (wr_ptr_reg[PTR_W-1:0] == rd_ptr_reg[PTR_W-1:0]));
   assign out_valid = (wr_ptr_reg != rd_ptr_reg);
   assign out_data = mem[rd_ptr_reg[PTR_W-1:0]];
   assign push = clk_en && in_valid && in_ready;
   assign pop = clk_en && out_valid && out_ready;

   // storage has no reset, contents are qualified by the pointers
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg[PTR_W-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end
endmodule

// file: logic/exb_port_pkg.sv
// shared constants and carrier types for the external bus port
package exb_port_pkg;
   // ==========================================================
   // widths and fifo depth
   localparam int DATA_W = 8;
   localparam int RAM_ADDR_W = 10;
   localparam int SYNC_W = 15;
   localparam int FIFO_DEPTH = 32;
   // ==========================================================
   // timing, in internal clocks
   localparam int XFER_CLOCKS = 2;
   localparam int USB_WAIT_MAX = 2;
   localparam int SYNC_STAGES = 2;
   // ==========================================================
   // interrupt pin source selection
   localparam logic [1:0] INT_SEL_TX = 2'h0;
   localparam logic [1:0] INT_SEL_RX = 2'h1;
   localparam logic [1:0] INT_SEL_MCH = 2'h2;
   // ==========================================================
   // status byte field positions
   localparam int STS_TX_FULL = 0;
   localparam int STS_RX_READY = 1;
   localparam int STS_MCH_REQ = 2;
   localparam int STS_MCH_END = 3;
   // ==========================================================
   // reset values
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   localparam logic [RAM_ADDR_W-1:0] ADDR_RST = 10'h000;

   // memory channel sequencer, gray along idle-wait-xfer-done
   typedef enum logic [1:0] {
      MCH_IDLE = 2'b00,
      MCH_WAIT = 2'b01,
      MCH_XFER = 2'b11,
      MCH_DONE = 2'b10
   } mch_state_t;

   // synchronised view of the external pins
   typedef struct packed {
      logic chip_select_n;
      logic channel_select;
      logic read_strobe_n;
      logic write_strobe_n;
      logic ack_n;
      logic terminal_count;
      logic status_select;
      logic [DATA_W-1:0] data;
   } pin_sample_t;

   // internal multichannel ram port
   typedef struct packed {
      logic req;
      logic we;
      logic [RAM_ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } ram_cmd_t;
endpackage

// file: logic/external_mcu_bus_port.sv
// external mcu parallel bus port with cpu channel and memory channel
// Overview of operation
// - cpu channel bytes are exchanged with the on-chip processor, flagged by interrupt
// - memory channel moves bytes between buffer and multichannel ram without the processor
// - burst setting makes the memory channel run at its fastest rate
// - after a synced strobe rising edge the ram transfer completes in two clocks
// - usb ram access wins; memory channel may wait up to two more clocks
// - at 8 MHz about 2 Mbytes/s, about 1.3 Mbytes/s with usb traffic
// - at 6 MHz about 1.5 Mbytes/s, about 1 Mbytes/s with usb traffic
// - four control inputs: chip select, channel select, read and write strobes
// - eight-bit two-way data bus and one interrupt output to the mcu
// - dma pins and status select pin each enabled separately by configuration
// - channel select low accesses ram at an address that increments per access
// - request pulses per byte without burst, held until end address with burst
// - dma acknowledge low acts as chip select low with channel select low
`timescale 1ns/1ps
module external_mcu_bus_port
   import exb_port_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   // external mcu pins
   input wire logic ext_chip_select_n,
   input wire logic ext_channel_select,
   input wire logic ext_read_strobe_n,
   input wire logic ext_write_strobe_n,
   input wire logic [DATA_W-1:0] ext_data_bus_in,
   output logic [DATA_W-1:0] ext_data_bus_out,
   output logic ext_data_bus_oe_n,
   output logic ext_interrupt_out,
   output logic dma_request_out,
   input wire logic dma_ack_n,
   input wire logic dma_terminal_count,
   input wire logic buffer_status_select,
   // configuration from the processor
   input wire logic burst_mode,
   input wire logic dma_pins_enable,
   input wire logic status_select_enable,
   input wire logic [1:0] int_source_select,
   input wire logic mem_channel_enable,
   input wire logic mem_dir_read,
   input wire logic mem_addr_load,
   input wire logic [RAM_ADDR_W-1:0] mem_start_addr,
   input wire logic [RAM_ADDR_W-1:0] mem_end_addr,
   // processor side of the cpu channel
   output logic cpu_rx_valid,
   input wire logic cpu_rx_ready,
   output logic [DATA_W-1:0] cpu_rx_data,
   input wire logic cpu_tx_valid,
   output logic cpu_tx_ready,
   input wire logic [DATA_W-1:0] cpu_tx_data,
   // multichannel ram, usb has priority
   input wire logic usb_ram_busy,
   output ram_cmd_t ram_cmd,
   input wire logic [DATA_W-1:0] ram_rdata,
   output logic [RAM_ADDR_W-1:0] mem_addr_count,
   output logic mem_end_reached
);
   // ==========================================================
   // pin synchronisation
   pin_sample_t pin_raw;
   pin_sample_t pin_sync_v;
   pin_sample_t pin_rst_v;
   logic rd_prev_reg;
   logic wr_prev_reg;

   assign pin_raw = '{chip_select_n: ext_chip_select_n, channel_select: ext_channel_select,
                      read_strobe_n: ext_read_strobe_n, write_strobe_n: ext_write_strobe_n,
                      ack_n: dma_ack_n, terminal_count: dma_terminal_count,
                      status_select: buffer_status_select, data: ext_data_bus_in};
   // reset to idle pins, so no strobe edge or bus drive follows reset
   assign pin_rst_v = '{chip_select_n: 1'b1, read_strobe_n: 1'b1, write_strobe_n: 1'b1, ack_n: 1'b1, default: 1'b0};

   pin_sync #(.WIDTH(SYNC_W)) u_sync (
      .clk(clk),
      .rst(rst),
      .clk_en(clk_en),
      .async_in(pin_raw),
      .rst_value(pin_rst_v),
      .sync_out(pin_sync_v)
   );

   // ==========================================================
   // access decode on synced levels
   logic dack_act;
   logic mem_sel;
   logic cpu_sel;
   logic rd_rise;
   logic wr_rise;
   logic rd_active;
   logic sts_sel;

   assign dack_act = dma_pins_enable && !pin_sync_v.ack_n;
   assign mem_sel = (!pin_sync_v.chip_select_n && !pin_sync_v.channel_select) || dack_act;
   assign cpu_sel = !pin_sync_v.chip_select_n && pin_sync_v.channel_select && !dack_act;
   assign sts_sel = status_select_enable && pin_sync_v.status_select;
   // strobes idle high; rising edge ends an access
   assign rd_rise = !rd_prev_reg && pin_sync_v.read_strobe_n;
   assign wr_rise = !wr_prev_reg && pin_sync_v.write_strobe_n;
   assign rd_active = !pin_sync_v.read_strobe_n && (mem_sel || !pin_sync_v.chip_select_n);

   // strobe history, starts idle so no edge is seen out of reset
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_prev_reg <= 1'b1;
         wr_prev_reg <= 1'b1;
      end else if (clk_en) begin
         rd_prev_reg <= pin_sync_v.read_strobe_n;
         wr_prev_reg <= pin_sync_v.write_strobe_n;
      end
   end

   // ==========================================================
   // cpu channel: receive fifo and transmit buffer
   logic rx_push;
   logic rx_ready;
   logic [DATA_W-1:0] tx_buf_reg;
   logic tx_full_reg;

   // a write while the fifo is full is refused; rx_ready tells the mcu to hold off
   assign rx_push = wr_rise && cpu_sel && !sts_sel;

   byte_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .clk(clk),
      .rst(rst),
      .clk_en(clk_en),
      .in_valid(rx_push),
      .in_ready(rx_ready),
      .in_data(pin_sync_v.data),
      .out_valid(cpu_rx_valid),
      .out_ready(cpu_rx_ready),
      .out_data(cpu_rx_data)
   );

   assign cpu_tx_ready = !tx_full_reg;

   // load from processor, emptied by an mcu read; an accepted load wins, ready promised it
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_buf_reg <= DATA_RST;
         tx_full_reg <= 1'b0;
      end else if (clk_en) begin
         if (cpu_tx_valid && !tx_full_reg) begin
            tx_buf_reg <= cpu_tx_data;
            tx_full_reg <= 1'b1;
         end else if (rd_rise && cpu_sel && !sts_sel) begin
            tx_full_reg <= 1'b0;
         end
      end
   end

   // ==========================================================
   // memory channel sequencer
   mch_state_t mch_state_reg;
   logic [DATA_W-1:0] mem_buf_reg;
   logic [RAM_ADDR_W-1:0] addr_reg;
   logic end_reg;
   logic mch_start;
   logic en_prev_reg;

   // a read edge consumes the buffer and refills it; enabling for read prefetches
   assign mch_start = mem_channel_enable && !end_reg &&
                      (((rd_rise && mem_dir_read) || (wr_rise && !mem_dir_read)) && mem_sel ||
                       (mem_dir_read && !en_prev_reg));

   // wait only while usb holds the ram, then two clocks to finish
   always_ff @(posedge clk) begin
      if (rst) begin
         mch_state_reg <= MCH_IDLE;
      end else if (clk_en) begin
         case (mch_state_reg)
            MCH_IDLE: begin
               if (mch_start) begin
                  mch_state_reg <= MCH_WAIT;
               end
            end
            MCH_WAIT: begin
               if (!usb_ram_busy) begin
                  mch_state_reg <= MCH_XFER;
               end
            end
            MCH_XFER: begin
               mch_state_reg <= MCH_DONE;
            end
            MCH_DONE: begin
               mch_state_reg <= MCH_IDLE;
            end
            default: begin
               mch_state_reg <= MCH_IDLE;
            end
         endcase
      end
   end

   // ram command is registered so it reaches the ram straight from flops
   always_ff @(posedge clk) begin
      if (rst) begin
         ram_cmd <= '0;
      end else if (clk_en) begin
         ram_cmd.req <= (mch_state_reg == MCH_WAIT) && !usb_ram_busy;
         ram_cmd.we <= (mch_state_reg == MCH_WAIT) && !usb_ram_busy && !mem_dir_read;
         ram_cmd.addr <= addr_reg;
         ram_cmd.wdata <= mem_buf_reg;
      end
   end

   // byte buffer: mcu writes land here, ram reads return here
   always_ff @(posedge clk) begin
      if (rst) begin
         mem_buf_reg <= DATA_RST;
      end else if (clk_en) begin
         if (wr_rise && mem_sel && !mem_dir_read && mch_state_reg == MCH_IDLE) begin
            mem_buf_reg <= pin_sync_v.data;
         end else if (mch_state_reg == MCH_DONE && mem_dir_read) begin
            mem_buf_reg <= ram_rdata;
         end
      end
   end

   // address counter: loadable only while disabled, counts after each access
   always_ff @(posedge clk) begin
      if (rst) begin
         addr_reg <= ADDR_RST;
         end_reg <= 1'b0;
         en_prev_reg <= 1'b0;
      end else if (clk_en) begin
         en_prev_reg <= mem_channel_enable;
         if (!mem_channel_enable) begin
            end_reg <= 1'b0;
            if (mem_addr_load) begin
               addr_reg <= mem_start_addr;
            end
         end else begin
            if (mch_state_reg == MCH_DONE) begin
               addr_reg <= addr_reg + 1'b1;
            end
            // tc is caught at the strobe edge; the ack is gone once the byte is done
            if ((mch_state_reg == MCH_DONE && addr_reg == mem_end_addr) ||
                (mch_start && dack_act && pin_sync_v.terminal_count)) begin
               end_reg <= 1'b1;
            end
         end
      end
   end

   assign mem_addr_count = addr_reg;
   assign mem_end_reached = end_reg;

   // ==========================================================
   // memory channel request
   logic mch_req_reg;
   logic req_next;

   // burst holds request to the end address; otherwise one request per byte,
   // dropped as soon as the strobe starts and raised again when the byte is done
   always_comb begin
      req_next = mch_req_reg;
      if (!mem_channel_enable || end_reg) begin
         req_next = 1'b0;
      end else if (burst_mode) begin
         req_next = 1'b1;
      end else if (mem_sel && (!pin_sync_v.read_strobe_n || !pin_sync_v.write_strobe_n)) begin
         req_next = 1'b0;
      end else if (mch_state_reg == MCH_DONE || (!en_prev_reg && !mem_dir_read)) begin
         req_next = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mch_req_reg <= 1'b0;
      end else if (clk_en) begin
         mch_req_reg <= req_next;
      end
   end

   // ==========================================================
   // pin outputs, all registered
   logic [DATA_W-1:0] status_byte;
   logic int_next;

   always_comb begin
      status_byte = DATA_RST;
      status_byte[STS_TX_FULL] = tx_full_reg;
      status_byte[STS_RX_READY] = rx_ready;
      status_byte[STS_MCH_REQ] = mch_req_reg;
      status_byte[STS_MCH_END] = end_reg;
      case (int_source_select)
         INT_SEL_TX: int_next = tx_full_reg;
         INT_SEL_RX: int_next = rx_ready;
         INT_SEL_MCH: int_next = mch_req_reg;
         default: int_next = tx_full_reg;
      endcase
   end

   // data bus driven only during a read; oe_n low means driving
   always_ff @(posedge clk) begin
      if (rst) begin
         ext_data_bus_out <= DATA_RST;
         ext_data_bus_oe_n <= 1'b1;
         ext_interrupt_out <= 1'b0;
         dma_request_out <= 1'b0;
      end else if (clk_en) begin
         ext_data_bus_oe_n <= !rd_active;
         if (sts_sel) begin
            ext_data_bus_out <= status_byte;
         end else if (cpu_sel) begin
            ext_data_bus_out <= tx_buf_reg;
         end else begin
            ext_data_bus_out <= mem_buf_reg;
         end
         ext_interrupt_out <= int_next;
         // pin stays at its inactive port level unless dma use is enabled
         dma_request_out <= dma_pins_enable && req_next;
      end
   end

   // ==========================================================
   // checks
   // the two clocks are fixed, so throughput depends on the mcu spacing
   done_two_clk_a: assert property (@(posedge clk) disable iff (rst)
      clk_en && mch_state_reg == MCH_WAIT && !usb_ram_busy ##1 clk_en |-> mch_state_reg == MCH_XFER ##1
      (!clk_en || mch_state_reg == MCH_DONE)) else $error("transfer not done in two clocks");
   usb_priority_a: assert property (@(posedge clk) disable iff (rst)
      usb_ram_busy |=> !ram_cmd.req) else $error("ram request during usb access");
   start_wait_a: assert property (@(posedge clk) disable iff (rst)
      clk_en && mch_state_reg == MCH_IDLE && mch_start |=> mch_state_reg == MCH_WAIT)
      else $error("memory access not started");
   addr_step_a: assert property (@(posedge clk) disable iff (rst)
      clk_en && mem_channel_enable && mch_state_reg == MCH_DONE |=> addr_reg == $past(addr_reg) + 1'b1)
      else $error("address did not increment");
   burst_hold_a: assert property (@(posedge clk) disable iff (rst)
      clk_en && burst_mode && mem_channel_enable && !end_reg |=> mch_req_reg)
      else $error("burst request dropped early");
   byte_drop_a: assert property (@(posedge clk) disable iff (rst)
      clk_en && !burst_mode && mem_sel && !pin_sync_v.write_strobe_n |=> !mch_req_reg)
      else $error("single request held through strobe");
   dack_mem_a: assert property (@(posedge clk) disable iff (rst)
      dma_pins_enable && !pin_sync_v.ack_n |-> mem_sel && !cpu_sel) else $error("ack not a memory access");
   dreq_gate_a: assert property (@(posedge clk) disable iff (rst)
      !$past(dma_pins_enable) |-> !dma_request_out) else $error("request pin active while disabled");
   cpu_write_a: assert property (@(posedge clk) disable iff (rst)
      clk_en && rx_push && rx_ready |=> cpu_rx_valid) else $error("cpu channel byte lost");
   bus_drive_a: assert property (@(posedge clk) disable iff (rst)
      clk_en && pin_sync_v.read_strobe_n && !dack_act ##1 clk_en |-> ##0 ext_data_bus_oe_n)
      else $error("data bus driven without read");

   cov_usb_wait_c: cover property (@(posedge clk) mch_state_reg == MCH_WAIT && usb_ram_busy ##1
      mch_state_reg == MCH_WAIT ##1 mch_state_reg == MCH_XFER);
   cov_burst_end_c: cover property (@(posedge clk) burst_mode && mch_req_reg ##1 end_reg);
   cov_cpu_rd_c: cover property (@(posedge clk) rd_rise && cpu_sel);
   cov_dack_wr_c: cover property (@(posedge clk) wr_rise && dack_act);
endmodule

// file: logic/pin_sync.sv
// two-stage synchroniser for the asynchronous external pins
`timescale 1ns/1ps
module pin_sync
   import exb_port_pkg::*;
#(
   parameter int WIDTH = SYNC_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [WIDTH-1:0] async_in,
   input wire logic [WIDTH-1:0] rst_value,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   // ==========================================================
   // first stage is read only by the second stage
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_reg <= rst_value;
         sync_out <= rst_value;
      end else if (clk_en) begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

// file: verif/external_mcu_bus_port_tb.sv
// self-checking bench for the external mcu bus port
`timescale 1ns/1ps
module external_mcu_bus_port_tb;
   import exb_port_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic clk_en, ext_chip_select_n, ext_channel_select, ext_read_strobe_n, ext_write_strobe_n, ext_data_bus_oe_n;
   logic ext_interrupt_out, dma_request_out, dma_ack_n, dma_terminal_count, buffer_status_select, burst_mode;
   logic dma_pins_enable, status_select_enable, mem_channel_enable, mem_dir_read, mem_addr_load, cpu_rx_valid;
   logic cpu_rx_ready, cpu_tx_valid, cpu_tx_ready, usb_ram_busy, mem_end_reached;
   logic [DATA_W-1:0] ext_data_bus_in, ext_data_bus_out, cpu_rx_data, cpu_tx_data, ram_rdata, r;
   logic [1:0] int_source_select;
   logic [RAM_ADDR_W-1:0] mem_start_addr, mem_end_addr, mem_addr_count;
   ram_cmd_t ram_cmd, last_cmd;
   int bad_count = 0, checks = 0, req_cnt = 0, cyc = 0, n;
   bit usb_noise = 1'b0;

   always #25 clk = ~clk;

   external_mcu_bus_port external_mcu_bus_port_i (.clk, .rst, .clk_en, .ext_chip_select_n, .ext_channel_select,
      .ext_read_strobe_n, .ext_write_strobe_n, .ext_data_bus_in, .ext_data_bus_out, .ext_data_bus_oe_n,
      .ext_interrupt_out, .dma_request_out, .dma_ack_n, .dma_terminal_count, .buffer_status_select, .burst_mode,
      .dma_pins_enable, .status_select_enable, .int_source_select, .mem_channel_enable, .mem_dir_read,
      .mem_addr_load, .mem_start_addr, .mem_end_addr, .cpu_rx_valid, .cpu_rx_ready, .cpu_rx_data, .cpu_tx_valid,
      .cpu_tx_ready, .cpu_tx_data, .usb_ram_busy, .ram_cmd, .ram_rdata, .mem_addr_count, .mem_end_reached);
   mcu_bus_model mcu_bus_model_i (.clk, .ext_data_bus_out, .ext_data_bus_oe_n, .ext_chip_select_n,
      .ext_channel_select, .ext_read_strobe_n, .ext_write_strobe_n, .dma_ack_n, .dma_terminal_count,
      .buffer_status_select, .ext_data_bus_in);

   // ==========================================================
   // ram model, usb contention and hang guard
   // usb toggles so each wait stays within the worst case of two clocks
   always @(posedge clk) begin
      ram_rdata <= ram_cmd.addr[7:0] ^ 8'hA5;
      usb_ram_busy <= usb_noise ? ~usb_ram_busy : 1'b0;
      if (ram_cmd.req) begin
         req_cnt++;
         last_cmd <= ram_cmd;
      end
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         end_of_test();
      end
   end

   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // start address loads only while the channel is off
   task automatic cfg(input logic rd, input logic bu, input logic [9:0] s, input logic [9:0] e);
      @(negedge clk);
      mem_channel_enable = 1'b0;
      mem_addr_load = 1'b1;
      mem_start_addr = s;
      mem_end_addr = e;
      mem_dir_read = rd;
      burst_mode = bu;
      @(negedge clk);
      mem_addr_load = 1'b0;
      mem_channel_enable = 1'b1;
      repeat (4) @(negedge clk);
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset();
      chk("oe_n", 1'b1, ext_data_bus_oe_n);
      chk("irq", 1'b0, ext_interrupt_out);
      chk("dreq", 1'b0, dma_request_out);
      chk("ram req", 1'b0, ram_cmd.req);
      chk("addr", 10'h000, mem_addr_count);
      $display("reset test done");
   endtask

   task automatic t_mem_write();
      cfg(1'b0, 1'b0, 10'h005, 10'h006);
      n = req_cnt;
      mcu_bus_model_i.access(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 8'h3C, r);
      chk("req count", n + 1, req_cnt);
      chk("ram cmd", {1'b1, 10'h005, 8'h3C}, {last_cmd.we, last_cmd.addr, last_cmd.wdata});
      chk("addr", 10'h006, mem_addr_count);
      chk("byte dreq", 1'b1, dma_request_out);
      usb_noise = 1'b1;
      mcu_bus_model_i.access(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 8'hC3, r);
      chk("ram cmd usb", {1'b1, 10'h006, 8'hC3}, {last_cmd.we, last_cmd.addr, last_cmd.wdata});
      chk("end", 1'b1, mem_end_reached);
      usb_noise = 1'b0;
      n = req_cnt;
      mcu_bus_model_i.access(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 8'h77, r);
      chk("req after end", n, req_cnt);
      $display("memory write test done");
   endtask

   task automatic t_burst_dma();
      cfg(1'b0, 1'b1, 10'h010, 10'h012);
      for (int i = 0; i < 3; i++) begin
         chk("burst dreq", 1'b1, dma_request_out);
         mcu_bus_model_i.access(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 8'h40 + i[7:0], r);
         chk("dack cmd", {1'b1, 10'h010 + i[9:0], 8'h40 + i[7:0]}, {last_cmd.we, last_cmd.addr, last_cmd.wdata});
      end
      chk("end", 1'b1, mem_end_reached);
      chk("dreq at end", 1'b0, dma_request_out);
      dma_pins_enable = 1'b0;
      cfg(1'b0, 1'b1, 10'h010, 10'h012);
      chk("dreq off", 1'b0, dma_request_out);
      dma_pins_enable = 1'b1;
      mcu_bus_model_i.dma_terminal_count = 1'b1;
      mcu_bus_model_i.access(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 8'h55, r);
      mcu_bus_model_i.dma_terminal_count = 1'b0;
      chk("tc end", {1'b1, 10'h011}, {mem_end_reached, mem_addr_count});
      $display("burst dma test done");
   endtask

   task automatic t_mem_read();
      int_source_select = INT_SEL_MCH;
      cfg(1'b1, 1'b0, 10'h020, 10'h03F);
      for (int i = 0; i < 2; i++) begin
         mcu_bus_model_i.access(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00, r);
         chk("mem read", 8'h20 + i[7:0] ^ 8'hA5, r);
      end
      chk("mch irq", 1'b1, ext_interrupt_out);
      $display("memory read test done");
   endtask

   task automatic t_cpu_tx();
      int_source_select = INT_SEL_TX;
      cpu_tx_data = 8'h5A;
      cpu_tx_valid = 1'b1;
      @(negedge clk);
      cpu_tx_valid = 1'b0;
      repeat (3) @(negedge clk);
      chk("tx irq", 1'b1, ext_interrupt_out);
      mcu_bus_model_i.access(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00, r);
      chk("cpu read", 8'h5A, r);
      chk("tx irq clear", 1'b0, ext_interrupt_out);
      chk("tx ready", 1'b1, cpu_tx_ready);
      $display("cpu transmit test done");
   endtask

   // fill the receive fifo past full while the processor stalls, then drain it
   task automatic t_cpu_fifo();
      int_source_select = INT_SEL_RX;
      status_select_enable = 1'b1;
      for (int i = 0; i < FIFO_DEPTH + 1; i++) begin
         mcu_bus_model_i.access(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, i[7:0], r);
      end
      mcu_bus_model_i.access(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 8'h00, r);
      chk("status", 2'b00, r[1:0]);
      chk("rx irq", 1'b0, ext_interrupt_out);
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         for (int k = 0; k < 20 && cpu_rx_valid !== 1'b1; k++) @(negedge clk);
         chk("rx data", i[7:0], cpu_rx_data);
         cpu_rx_ready = 1'b1;
         @(negedge clk);
         cpu_rx_ready = 1'b0;
      end
      repeat (3) @(negedge clk);
      chk("rx empty", 1'b0, cpu_rx_valid);
      chk("rx irq", 1'b1, ext_interrupt_out);
      $display("cpu fifo test done");
   endtask

   initial begin
      clk_en = 1'b1;
      burst_mode = 1'b0;
      dma_pins_enable = 1'b1;
      status_select_enable = 1'b0;
      int_source_select = INT_SEL_TX;
      mem_channel_enable = 1'b0;
      mem_dir_read = 1'b0;
      mem_addr_load = 1'b0;
      mem_start_addr = ADDR_RST;
      mem_end_addr = ADDR_RST;
      cpu_rx_ready = 1'b0;
      cpu_tx_valid = 1'b0;
      cpu_tx_data = DATA_RST;
      usb_ram_busy = 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      t_reset();
      t_mem_write();
      t_burst_dma();
      t_mem_read();
      t_cpu_tx();
      t_cpu_fifo();
      end_of_test();
   end
endmodule

// file: verif/mcu_bus_model.sv
// external mcu and dma controller model that drives the port's pins
`timescale 1ns/1ps
module mcu_bus_model
   import exb_port_pkg::*;
(
   input wire logic clk,
   input wire logic [DATA_W-1:0] ext_data_bus_out,
   input wire logic ext_data_bus_oe_n,
   output logic ext_chip_select_n,
   output logic ext_channel_select,
   output logic ext_read_strobe_n,
   output logic ext_write_strobe_n,
   output logic dma_ack_n,
   output logic dma_terminal_count,
   output logic buffer_status_select,
   output logic [DATA_W-1:0] ext_data_bus_in
);
   logic drive = 1'b0;
   logic [DATA_W-1:0] wval = 8'h00;
   logic [DATA_W-1:0] last = 8'h00;
   // ==========================================================
   // shared data bus
   // a released bus toggles every cycle so a stale byte can never pass for a good one
   assign ext_data_bus_in = drive ? wval : (!ext_data_bus_oe_n ? ext_data_bus_out : ~last);
   always @(posedge clk) begin
      last <= ext_data_bus_in;
   end
   // pins idle from time zero, strobes high long before any access
   initial begin
      ext_chip_select_n = 1'b1;
      ext_channel_select = 1'b0;
      ext_read_strobe_n = 1'b1;
      ext_write_strobe_n = 1'b1;
      dma_ack_n = 1'b1;
      dma_terminal_count = 1'b0;
      buffer_status_select = 1'b0;
   end
   // ==========================================================
   // one byte access; select and data set a cycle before the strobe and held past its rise
   task automatic access(input logic cs, input logic ack, input logic ch, input logic sel, input logic wr,
                         input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
      @(negedge clk);
      ext_chip_select_n = cs;
      dma_ack_n = ack;
      ext_channel_select = ch;
      buffer_status_select = sel;
      drive = wr;
      wval = wd;
      @(negedge clk);
      if (wr) begin
         ext_write_strobe_n = 1'b0;
      end else begin
         ext_read_strobe_n = 1'b0;
      end
      repeat (5) @(negedge clk);
      rd = ext_data_bus_in;
      ext_write_strobe_n = 1'b1;
      ext_read_strobe_n = 1'b1;
      repeat (2) @(negedge clk);
      ext_chip_select_n = 1'b1;
      dma_ack_n = 1'b1;
      buffer_status_select = 1'b0;
      drive = 1'b0;
      // gap covers sync, usb wait and the two-clock transfer
      repeat (8) @(negedge clk);
   endtask
endmodule
